// ===== design/peba_host.sv
// Purpose: host controller issuing reads, byte writes and chip clear to the eeprom
// Assumes: device pins reach the board directly; 50 MHz clock
// Notes: busy line is open drain with external pull-up
`timescale 1ns/1ns
module peba_host #(
    parameter int WC_CYC = peba_pkg::WC_STD_CYC,
    parameter int CLEAR_CYC = peba_pkg::CLEAR_CYC,
    parameter int PON_CYC = peba_pkg::PON_CYC
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic req_valid,
    output logic req_ready,
    input wire peba_pkg::peba_op_type req_op,
    input wire logic [10:0] req_addr,
    input wire logic [7:0] req_wdata,
    input wire logic req_id_area,
    output logic rsp_valid,
    output logic [7:0] rsp_rdata,
    output logic rsp_timeout,
    output logic [10:0] byte_address,
    output logic chip_enable_n,
    output logic output_enable_n,
    output logic write_enable_n,
    output logic oe_high_voltage,
    output logic id_select_high_voltage_pin,
    input wire logic [7:0] data_pins_in,
    output logic [7:0] data_pins_out,
    output logic data_pins_oe_n,
    input wire logic write_done_flag
);
    // ========================================
    // state
    // ========================================
    typedef enum logic [3:0] {
        PEBA_S_PON, PEBA_S_IDLE, PEBA_S_RD_ACC, PEBA_S_RD_END, PEBA_S_WR_SET,
        PEBA_S_WR_PULSE, PEBA_S_WR_HOLD, PEBA_S_POLL, PEBA_S_CLR_SET,
        PEBA_S_CLR_PULSE, PEBA_S_CLR_HOLD, PEBA_S_DONE
    } peba_state_type;

    peba_state_type state_reg;
    logic [peba_pkg::TMR_W-1:0] tmr_reg;
    logic [7:0] wdata_reg;
    logic [7:0] data_s;
    logic busy_s;
    logic tmr_zero;

    peba_sync #(.W(9), .INIT(9'h100)) u_sync (
        .clk(clk),
        .srst(srst),
        .d({write_done_flag, data_pins_in}),
        .q({busy_s, data_s})
    );

    assign tmr_zero = (tmr_reg == '0);
    assign req_ready = (state_reg == PEBA_S_IDLE);

    function automatic logic [peba_pkg::TMR_W-1:0] cyc(input int n);
        cyc = peba_pkg::TMR_W'(n - 1);
    endfunction

    // ========================================
    // sequencer
    // ========================================
    always_ff @(posedge clk) begin
        if (srst) begin
            state_reg <= PEBA_S_PON;
            tmr_reg <= '0;
        end else begin
            if (!tmr_zero) begin
                tmr_reg <= tmr_reg - 1'b1;
            end
            case (state_reg)
                PEBA_S_PON: begin
                    if (tmr_zero) begin
                        tmr_reg <= cyc(PON_CYC);
                        state_reg <= PEBA_S_DONE;
                    end
                end
                PEBA_S_DONE: begin
                    if (tmr_zero) begin
                        state_reg <= PEBA_S_IDLE;
                    end
                end
                PEBA_S_IDLE: begin
                    if (req_valid) begin
                        case (req_op)
                            peba_pkg::PEBA_OP_WRITE: begin
                                state_reg <= PEBA_S_WR_SET;
                                tmr_reg <= cyc(peba_pkg::SETUP_CYC);
                            end
                            peba_pkg::PEBA_OP_CLEAR: begin
                                state_reg <= PEBA_S_CLR_SET;
                                tmr_reg <= cyc(peba_pkg::SETUP_CYC);
                            end
                            default: begin
                                state_reg <= PEBA_S_RD_ACC;
                                tmr_reg <= cyc(peba_pkg::ACC_CYC);
                            end
                        endcase
                    end
                end
                PEBA_S_RD_ACC: begin
                    if (tmr_zero) begin
                        state_reg <= PEBA_S_RD_END;
                        tmr_reg <= cyc(peba_pkg::FLOAT_CYC);
                    end
                end
                PEBA_S_RD_END: begin
                    if (tmr_zero) begin
                        state_reg <= PEBA_S_IDLE;
                    end
                end
                PEBA_S_WR_SET: begin
                    if (tmr_zero) begin
                        state_reg <= PEBA_S_WR_PULSE;
                        tmr_reg <= cyc(peba_pkg::PULSE_CYC);
                    end
                end
                PEBA_S_WR_PULSE: begin
                    if (tmr_zero) begin
                        state_reg <= PEBA_S_WR_HOLD;
                        tmr_reg <= cyc(peba_pkg::HOLD_CYC);
                    end
                end
                PEBA_S_WR_HOLD: begin
                    if (tmr_zero) begin
                        state_reg <= PEBA_S_POLL;
                        tmr_reg <= cyc(WC_CYC);
                    end
                end
                // wait for release of busy or timeout
                PEBA_S_POLL: begin
                    if (busy_s || tmr_zero) begin
                        state_reg <= PEBA_S_IDLE;
                    end
                end
                PEBA_S_CLR_SET: begin
                    if (tmr_zero) begin
                        state_reg <= PEBA_S_CLR_PULSE;
                        tmr_reg <= cyc(CLEAR_CYC);
                    end
                end
                PEBA_S_CLR_PULSE: begin
                    if (tmr_zero) begin
                        state_reg <= PEBA_S_CLR_HOLD;
                        tmr_reg <= cyc(peba_pkg::SETUP_CYC);
                    end
                end
                PEBA_S_CLR_HOLD: begin
                    if (tmr_zero) begin
                        state_reg <= PEBA_S_IDLE;
                    end
                end
                default: begin
                    state_reg <= PEBA_S_IDLE;
                end
            endcase
        end
    end

    // ========================================
    // pin drive
    // ========================================
    always_ff @(posedge clk) begin
        if (srst) begin
            byte_address <= '0;
            wdata_reg <= '0;
            id_select_high_voltage_pin <= 1'b0;
        end else if (state_reg == PEBA_S_IDLE && req_valid) begin
            byte_address <= req_addr;
            wdata_reg <= req_wdata;
            id_select_high_voltage_pin <= req_id_area && (req_addr >= peba_pkg::ID_BASE);
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            chip_enable_n <= 1'b1;
            output_enable_n <= 1'b1;
            write_enable_n <= 1'b1;
            oe_high_voltage <= 1'b0;
            data_pins_out <= '0;
            data_pins_oe_n <= 1'b1;
        end else begin
            chip_enable_n <= !(state_reg == PEBA_S_RD_ACC || state_reg == PEBA_S_WR_SET ||
                state_reg == PEBA_S_WR_PULSE || state_reg == PEBA_S_CLR_SET ||
                state_reg == PEBA_S_CLR_PULSE || state_reg == PEBA_S_CLR_HOLD);
            output_enable_n <= !(state_reg == PEBA_S_RD_ACC);
            // write pulse with output enable high
            write_enable_n <= !(state_reg == PEBA_S_WR_PULSE || state_reg == PEBA_S_CLR_PULSE);
            oe_high_voltage <= (state_reg == PEBA_S_CLR_SET || state_reg == PEBA_S_CLR_PULSE ||
                state_reg == PEBA_S_CLR_HOLD);
            data_pins_out <= wdata_reg;
            data_pins_oe_n <= !(state_reg == PEBA_S_WR_SET || state_reg == PEBA_S_WR_PULSE ||
                state_reg == PEBA_S_WR_HOLD);
        end
    end

    // ========================================
    // answer
    // ========================================
    always_ff @(posedge clk) begin
        if (srst) begin
            rsp_valid <= 1'b0;
            rsp_rdata <= '0;
            rsp_timeout <= 1'b0;
        end else begin
            rsp_valid <= 1'b0;
            if (state_reg == PEBA_S_RD_ACC && tmr_zero) begin
                rsp_valid <= 1'b1;
                rsp_rdata <= data_s;
                rsp_timeout <= 1'b0;
            end else if (state_reg == PEBA_S_POLL && (busy_s || tmr_zero)) begin
                rsp_valid <= 1'b1;
                rsp_timeout <= !busy_s;
            end else if (state_reg == PEBA_S_CLR_HOLD && tmr_zero) begin
                rsp_valid <= 1'b1;
                rsp_timeout <= 1'b0;
            end
        end
    end

    // output enable high during write pulse
    chk_we_oe_excl: assert property (@(posedge clk) disable iff (srst)
        !write_enable_n |-> output_enable_n)
        else $error("write strobe with output enable low");
    // no bus fight: host drives only while device output enable high
    chk_bus_contention: assert property (@(posedge clk) disable iff (srst)
        !data_pins_oe_n |-> output_enable_n)
        else $error("host drives data while output enable low");
    chk_poll_quiet: assert property (@(posedge clk) disable iff (srst)
        (state_reg == PEBA_S_POLL) |-> (chip_enable_n && write_enable_n && !req_ready))
        else $error("access during write cycle");
    // no request taken in first 8 cycles of power-on window
    chk_pon_lock: assert property (@(posedge clk) disable iff (srst)
        $rose(state_reg == PEBA_S_DONE) |-> !req_ready [*8])
        else $error("ready during power-on delay");
    chk_we_pulse: assert property (@(posedge clk) disable iff (srst)
        ($fell(write_enable_n) && !oe_high_voltage) |-> !write_enable_n [*5] ##1 write_enable_n)
        else $error("write pulse width wrong");
    // clear has chip enable low and high voltage
    chk_clear_qual: assert property (@(posedge clk) disable iff (srst)
        (!write_enable_n && oe_high_voltage) |-> !chip_enable_n)
        else $error("clear pulse without chip enable");
    // data stable while write strobe rises
    chk_data_hold: assert property (@(posedge clk) disable iff (srst)
        $rose(write_enable_n) && !oe_high_voltage |-> !data_pins_oe_n && $stable(data_pins_out))
        else $error("data not held at write end");
    chk_poll_bound: assert property (@(posedge clk) disable iff (srst)
        (state_reg == PEBA_S_POLL && tmr_zero && !busy_s) |=> (rsp_valid && rsp_timeout && req_ready))
        else $error("poll not ended with timeout at write limit");
endmodule

// ===== design/peba_pkg.sv
// Purpose: constants for the host-side controller of a parallel byte-wide eeprom
// Assumes: 50 MHz clock, 20 ns period
// Notes: device pins are driven by the controller; device map held here
//
// Summary of operation
// - write starts by write or chip enable low pulse, output enable high
// - host starts new access only after detecting end of write or reaching the write-cycle timeout
// - chip enable low, output enable at 12 V, 10 ms write pulse clears all
// - high voltage on id pin maps 7e0..7ff to 32-byte id area
package peba_pkg;
    localparam int ADDR_W = 11;
    localparam int DATA_W = 8;
    localparam int CLK_NS = 20;
    // strobe timing, printed in ns
    localparam int SETUP_NS = 50;
    localparam int PULSE_NS = 100;
    localparam int HOLD_NS = 50;
    localparam int ACC_NS = 150;
    localparam int FLOAT_NS = 50;
    localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int PULSE_CYC = (PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int HOLD_CYC = (HOLD_NS + CLK_NS - 1) / CLK_NS;
    localparam int ACC_CYC = (ACC_NS + CLK_NS - 1) / CLK_NS + 2;
    localparam int FLOAT_CYC = (FLOAT_NS + CLK_NS - 1) / CLK_NS;
    // write cycle limits in us, chip clear pulse in ms, power-on delay in ms
    localparam int WC_STD_US = 1000;
    localparam int WC_FAST_US = 200;
    localparam int CLEAR_MS = 10;
    localparam int PON_MS = 5;
    localparam int WC_STD_CYC = WC_STD_US * 1000 / CLK_NS;
    localparam int WC_FAST_CYC = WC_FAST_US * 1000 / CLK_NS;
    localparam int CLEAR_CYC = CLEAR_MS * 1000000 / CLK_NS;
    localparam int PON_CYC = PON_MS * 1000000 / CLK_NS;
    localparam logic [10:0] ID_BASE = 11'h7e0;
    localparam logic [10:0] ID_LAST = 11'h7ff;
    localparam int MSB = 7;
    localparam int TMR_W = 24;
    typedef enum logic [1:0] {
        PEBA_OP_READ,
        PEBA_OP_WRITE,
        PEBA_OP_CLEAR
    } peba_op_type;
endpackage

// ===== design/peba_sync.sv
// Purpose: two flip-flop synchroniser for pin inputs
// Assumes: single clock domain
// Notes: first stage is read only by the second
`timescale 1ns/1ns
module peba_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_reg;
    always_ff @(posedge clk) begin
        if (srst) begin
            meta_reg <= INIT;
            q <= INIT;
        end else begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end
endmodule

// ===== bench/peba_eeprom_model.sv
// Purpose: behavioural byte-wide eeprom on the far side of the host controller
// Assumes: self-timed write counted on the bench clock
// Notes: stuck_busy holds the busy line low so the host times out
`timescale 1ns/1ns
module peba_eeprom_model #(
    parameter int WC = 60,
    parameter int PON = 10
) (
    input wire logic clk,
    input wire logic stuck_busy,
    input wire logic supply_low,
    input wire logic [10:0] byte_address,
    input wire logic chip_enable_n,
    input wire logic output_enable_n,
    input wire logic write_enable_n,
    input wire logic oe_high_voltage,
    input wire logic id_select_high_voltage_pin,
    input wire logic [7:0] data_bus,
    output logic [7:0] dev_data,
    output logic dev_drive,
    output logic busy_pull
);
    logic [7:0] mem [0:2047];
    logic [7:0] id_mem [0:31];
    logic [10:0] lat_a;
    logic [7:0] lat_d;
    logic lat_id, armed, busy;
    int tmr, pon;
    initial begin
        for (int i = 0; i < 2048; i++) mem[i] = i[7:0] ^ 8'h3c;
        for (int i = 0; i < 32; i++) id_mem[i] = 8'h00;
        armed = 1'b0;
        busy = 1'b0;
        tmr = 0;
        pon = 0;
    end
    always @(negedge write_enable_n or negedge chip_enable_n) begin
        if (!write_enable_n && !chip_enable_n && output_enable_n && !oe_high_voltage
            && !busy && !supply_low && pon >= PON) begin
            armed = 1'b1;
            lat_a = byte_address;
            lat_id = id_select_high_voltage_pin && byte_address >= 11'h7e0;
        end
    end
    // data on first rise, or whole-array clear
    always @(posedge write_enable_n or posedge chip_enable_n) begin
        if (armed) begin
            armed = 1'b0;
            lat_d = data_bus;
            busy = 1'b1;
            tmr = 0;
        end else if (oe_high_voltage && !chip_enable_n && write_enable_n) begin
            for (int i = 0; i < 2048; i++) mem[i] = 8'hff;
        end
    end
    // erase then program when the timer ends
    always @(posedge clk) begin
        if (pon < PON) pon++;
        if (busy) begin
            tmr++;
            if (tmr >= WC) begin
                if (lat_id) id_mem[lat_a[4:0]] = 8'hff;
                else mem[lat_a] = 8'hff;
                if (lat_id) id_mem[lat_a[4:0]] = lat_d;
                else mem[lat_a] = lat_d;
                busy = 1'b0;
            end
        end
    end
    // read path, polling status while busy
    assign dev_drive = !chip_enable_n && !output_enable_n && write_enable_n && !oe_high_voltage;
    assign dev_data = busy ? {~lat_d[7], tmr[6:0]} :
        (id_select_high_voltage_pin && byte_address >= 11'h7e0) ?
        id_mem[byte_address[4:0]] : mem[byte_address];
    assign busy_pull = busy || stuck_busy;
endmodule

// ===== bench/peba_host_tb.sv
// Purpose: self-checking bench for the eeprom host controller
// Assumes: shortened lockout, clear and write-timeout counts
// Notes: data bus floats to a toggling pattern when nobody drives it
`timescale 1ns/1ns
module peba_host_tb;
    localparam int PON = 20;
    localparam int CLR = 50;
    localparam int WC = 200;
    localparam int MWC = 60;
    logic clk, srst, req_valid, req_id_area, stuck_busy, req_ready, rsp_valid, rsp_timeout;
    peba_pkg::peba_op_type req_op;
    logic [10:0] req_addr, byte_address;
    logic [7:0] req_wdata, rsp_rdata, data_pins_out, dev_data, last_bus;
    logic chip_enable_n, output_enable_n, write_enable_n, oe_high_voltage, id_pin;
    logic data_pins_oe_n, dev_drive, busy_pull, supply_low;
    wire [7:0] data_bus;
    wire write_done_flag;
    int n_fail, n_tests, cyc;
    assign data_bus = !data_pins_oe_n ? data_pins_out : dev_drive ? dev_data : ~last_bus;
    assign write_done_flag = busy_pull ? 1'b0 : 1'b1;
    always @(posedge clk) last_bus <= data_bus;
    peba_host #(.WC_CYC(WC), .CLEAR_CYC(CLR), .PON_CYC(PON)) dut (.clk(clk), .srst(srst),
        .req_valid(req_valid), .req_ready(req_ready), .req_op(req_op), .req_addr(req_addr),
        .req_wdata(req_wdata), .req_id_area(req_id_area), .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata), .rsp_timeout(rsp_timeout), .byte_address(byte_address),
        .chip_enable_n(chip_enable_n), .output_enable_n(output_enable_n),
        .write_enable_n(write_enable_n), .oe_high_voltage(oe_high_voltage),
        .id_select_high_voltage_pin(id_pin), .data_pins_in(data_bus),
        .data_pins_out(data_pins_out), .data_pins_oe_n(data_pins_oe_n),
        .write_done_flag(write_done_flag));
    peba_eeprom_model #(.WC(MWC), .PON(10)) model (.clk(clk),
        .stuck_busy(stuck_busy), .supply_low(supply_low),
        .byte_address(byte_address), .chip_enable_n(chip_enable_n),
        .output_enable_n(output_enable_n), .write_enable_n(write_enable_n),
        .oe_high_voltage(oe_high_voltage), .id_select_high_voltage_pin(id_pin),
        .data_bus(data_bus), .dev_data(dev_data), .dev_drive(dev_drive), .busy_pull(busy_pull));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            $display("[ERR] %s expected %h seen %h", what, exp, got);
            n_fail++;
        end
    endtask
    task automatic req(input peba_pkg::peba_op_type op, input logic [10:0] a,
        input logic [7:0] d, input logic id);
        int i;
        i = 0;
        @(negedge clk);
        while (req_ready !== 1'b1 && i < 2000) begin
            @(negedge clk);
            i++;
        end
        req_op = op;
        req_addr = a;
        req_wdata = d;
        req_id_area = id;
        req_valid = 1'b1;
        @(negedge clk);
        req_valid = 1'b0;
        cyc = 1;
        while (rsp_valid !== 1'b1 && cyc < 2000) begin
            @(negedge clk);
            cyc++;
        end
        check("answer", 8'h01, {7'h00, rsp_valid});
    endtask
    task automatic t_reset();
        int i;
        i = 0;
        srst = 1'b1;
        repeat (2) @(negedge clk);
        srst = 1'b0;
        repeat (3) @(negedge clk);
        check("ready in lockout", 8'h00, {7'h00, req_ready});
        check("we idle", 8'h01, {7'h00, write_enable_n});
        while (req_ready !== 1'b1 && i < 200) begin
            @(negedge clk);
            i++;
        end
        check("lockout long", 8'h01, {7'h00, i >= PON - 4});
        $display("test reset done");
    endtask
    task automatic t_rw();
        logic [10:0] a [3] = '{11'h000, 11'h123, 11'h7ff};
        logic [7:0] d [3] = '{8'ha5, 8'h5a, 8'h01};
        for (int k = 0; k < 3; k++) begin
            req(peba_pkg::PEBA_OP_WRITE, a[k], d[k], 1'b0);
            check("timeout", 8'h00, {7'h00, rsp_timeout});
            check("waited busy", 8'h01, {7'h00, cyc >= MWC});
        end
        for (int k = 0; k < 3; k++) begin
            req(peba_pkg::PEBA_OP_READ, a[k], 8'h00, 1'b0);
            check("read back", d[k], rsp_rdata);
        end
        $display("test write read done");
    endtask
    task automatic t_clear_id();
        req(peba_pkg::PEBA_OP_CLEAR, 11'h000, 8'h00, 1'b0);
        req(peba_pkg::PEBA_OP_READ, 11'h123, 8'h00, 1'b0);
        check("cleared", 8'hff, rsp_rdata);
        req(peba_pkg::PEBA_OP_WRITE, 11'h7e5, 8'hc3, 1'b1);
        req(peba_pkg::PEBA_OP_READ, 11'h7e5, 8'h00, 1'b1);
        check("id byte", 8'hc3, rsp_rdata);
        req(peba_pkg::PEBA_OP_READ, 11'h7e5, 8'h00, 1'b0);
        check("main byte", 8'hff, rsp_rdata);
        $display("test clear id done");
    endtask
    task automatic t_timeout();
        stuck_busy = 1'b1;
        req(peba_pkg::PEBA_OP_WRITE, 11'h042, 8'h7e, 1'b0);
        check("timeout", 8'h01, {7'h00, rsp_timeout});
        stuck_busy = 1'b0;
        req(peba_pkg::PEBA_OP_READ, 11'h042, 8'h00, 1'b0);
        check("late write", 8'h7e, rsp_rdata);
        supply_low = 1'b1;
        req(peba_pkg::PEBA_OP_WRITE, 11'h042, 8'h11, 1'b0);
        supply_low = 1'b0;
        req(peba_pkg::PEBA_OP_READ, 11'h042, 8'h00, 1'b0);
        check("inhibited write", 8'h7e, rsp_rdata);
        $display("test timeout done");
    endtask
    always @(negedge clk) begin
        if (!srst && !data_pins_oe_n && dev_drive) begin
            n_fail++;
            $display("[ERR] bus contention expected 0 seen 1");
        end
        if (!srst && !write_enable_n && !output_enable_n) begin
            n_fail++;
            $display("[ERR] write with oe low expected 1 seen 0");
        end
        if (!srst && !write_enable_n && busy_pull && !stuck_busy) begin
            n_fail++;
            $display("[ERR] strobe while busy expected 1 seen 0");
        end
    end
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        #400000;
        n_fail++;
        $display("[ERR] watchdog expected done seen hang");
        print_verdict();
    end
    initial begin
        n_fail = 0;
        n_tests = 0;
        srst = 1'b1;
        req_valid = 1'b0;
        req_op = peba_pkg::PEBA_OP_READ;
        req_addr = 11'h000;
        req_wdata = 8'h00;
        req_id_area = 1'b0;
        stuck_busy = 1'b0;
        supply_low = 1'b0;
        last_bus = 8'h00;
        t_reset();
        t_rw();
        t_clear_id();
        t_timeout();
        t_reset();
        t_rw();
        print_verdict();
    end
endmodule
